/* tfcs_map.vh */
`ifndef TFCS_MAP_VH
`define TFCS_MAP_VH

// Register offsets
`define TFCS_ADDR_ALARM_CTRL   8'h30
`define TFCS_ADDR_ERRINJ_CTRL  8'h32
`define TFCS_ADDR_STATUS       8'h34

// Field positions
`define TFCS_RAI_LSB           0
`define TFCS_AIS_CTRL_LSB      8
`define TFCS_INJ_LSB           0
`define TFCS_NAT_LSB           8
`define TFCS_LOF_LSB           0
`define TFCS_IE_LOF_BIT        7
`define TFCS_AIS_LSB           8
`define TFCS_IE_AIS_BIT        15

// Reset values
`define TFCS_CH_RESET          7'h00
`define TFCS_NAT_RESET         4'h0
`define TFCS_IE_RESET          1'b0

// Multiplexing modes
`define TFCS_MODE_T3           2'h0
`define TFCS_MODE_E3           2'h1
`define TFCS_MODE_G747         2'h2

// Frame alignment words
`define TFCS_FAS_E3            10'h3d0
`define TFCS_FAS_G747          10'h1d0

// Counts
`define TFCS_INJ_BURST         3'h4
`define TFCS_LOF_BAD_CNT       3'h4
`define TFCS_LOF_GOOD_CNT      3'h3
`define TFCS_T2_ERR_LIMIT      3'h2

`endif

/* tfcs_ctrl_status.v */
// Functional notes
// - T3: X bit is inverse of remote alarm
// - E3: remote alarm sets E2 bit 11
// - G.747: remote alarm sets set-2 bit 1
// - E3/G.747: clear control sends RAI zero
// - All-ones control sends unframed all ones
// - Injection burst only on zero-to-one edge
// - T3 burst corrupts four F bits
// - E3 burst inverts four FAS words
// - G.747 burst inverts four FAS words
// - National bits forced only in E3 mode
// - Frame loss latches; read clears unless present
// - Frame loss change gated by enable, mask
// - Status read releases master interrupt request
// - All-ones alarm latches; read clears unless present
// - All-ones change gated by enable, mask
// - E2/G.747: four bad set, three good clear
// - T2: two of five F, two of four M
`timescale 1ns/1ps
`default_nettype none
`include "tfcs_map.vh"

module tfcs_chan
(
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [1:0] mode_i,
  input  wire       align_strobe_i,
  input  wire       align_bad_i,
  input  wire       fbit_strobe_i,
  input  wire       fbit_err_i,
  input  wire       mbit_strobe_i,
  input  wire       mbit_err_i,
  input  wire       t2_sync_i,
  input  wire       inject_rise_i,
  input  wire       frame_mark_i,
  output wire       frame_loss_o,
  output wire       inject_active_o,
  output reg  [9:0] fas_word_o
);

  reg  [2:0] bad_cnt_reg;
  reg  [2:0] bad_cnt_next;
  reg  [2:0] good_cnt_reg;
  reg  [2:0] good_cnt_next;
  reg  [4:0] f_hist_reg;
  reg  [4:0] f_hist_next;
  reg  [3:0] m_hist_reg;
  reg  [3:0] m_hist_next;
  reg        lof_reg;
  reg        lof_next;
  reg  [2:0] burst_reg;
  reg  [2:0] burst_next;
  wire [9:0] fas_norm;

  function [2:0] ones5;
    input [4:0] v;
    begin
      ones5 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]} + {2'b00, v[4]};
    end
  endfunction

  always @*
  begin
    bad_cnt_next  = bad_cnt_reg;
    good_cnt_next = good_cnt_reg;
    f_hist_next   = f_hist_reg;
    m_hist_next   = m_hist_reg;
    lof_next      = lof_reg;
    if (mode_i == `TFCS_MODE_T3)
    begin
      // Sliding error windows over the last F and M bits
      if (fbit_strobe_i)
        f_hist_next = {f_hist_reg[3:0], fbit_err_i};
      if (mbit_strobe_i)
        m_hist_next = {m_hist_reg[2:0], mbit_err_i};
      if (lof_reg)
      begin
        if (t2_sync_i)
        begin
          lof_next    = 1'b0;
          f_hist_next = 5'h00;
          m_hist_next = 4'h0;
        end
      end
      else if ((ones5(f_hist_next) >= `TFCS_T2_ERR_LIMIT) ||
               (ones5({1'b0, m_hist_next}) >= `TFCS_T2_ERR_LIMIT))
        lof_next = 1'b1;
    end
    else if (align_strobe_i)
    begin
      if (!lof_reg)
      begin
        good_cnt_next = 3'h0;
        if (!align_bad_i)
          bad_cnt_next = 3'h0;
        else if (bad_cnt_reg + 3'h1 >= `TFCS_LOF_BAD_CNT)
        begin
          bad_cnt_next = 3'h0;
          lof_next     = 1'b1;
        end
        else
          bad_cnt_next = bad_cnt_reg + 3'h1;
      end
      else
      begin
        bad_cnt_next = 3'h0;
        if (align_bad_i)
          good_cnt_next = 3'h0;
        else if (good_cnt_reg + 3'h1 >= `TFCS_LOF_GOOD_CNT)
        begin
          good_cnt_next = 3'h0;
          lof_next      = 1'b0;
        end
        else
          good_cnt_next = good_cnt_reg + 3'h1;
      end
    end
  end

  always @*
  begin
    burst_next = burst_reg;
    // A new edge restarts the burst at four frames
    if (inject_rise_i)
      burst_next = `TFCS_INJ_BURST;
    else if (frame_mark_i && (burst_reg != 3'h0))
      burst_next = burst_reg - 3'h1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bad_cnt_reg  <= 3'h0;
      good_cnt_reg <= 3'h0;
      f_hist_reg   <= 5'h00;
      m_hist_reg   <= 4'h0;
      lof_reg      <= 1'b0;
      burst_reg    <= 3'h0;
    end
    else
    begin
      bad_cnt_reg  <= bad_cnt_next;
      good_cnt_reg <= good_cnt_next;
      f_hist_reg   <= f_hist_next;
      m_hist_reg   <= m_hist_next;
      lof_reg      <= lof_next;
      burst_reg    <= burst_next;
    end
  end

  assign frame_loss_o    = lof_reg;
  assign inject_active_o = (burst_reg != 3'h0);
  assign fas_norm        = (mode_i == `TFCS_MODE_G747) ? `TFCS_FAS_G747 : `TFCS_FAS_E3;

  always @*
  begin
    fas_word_o = fas_norm;
    if (inject_active_o)
    begin
      if (mode_i == `TFCS_MODE_G747)
        fas_word_o = {1'b0, ~fas_norm[8:0]};
      else
        fas_word_o = ~fas_norm;
    end
  end

endmodule

module tfcs_ctrl_status
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire [1:0]  mode_i,
  input  wire [6:0]  align_strobe_i,
  input  wire [6:0]  align_bad_i,
  input  wire [6:0]  fbit_strobe_i,
  input  wire [6:0]  fbit_err_i,
  input  wire [6:0]  mbit_strobe_i,
  input  wire [6:0]  mbit_err_i,
  input  wire [6:0]  t2_sync_i,
  input  wire [6:0]  all_ones_det_i,
  input  wire [6:0]  frame_mark_i,
  input  wire        master_mask_i,
  output wire [6:0]  overhead_alarm_bit_o,
  output wire [6:0]  tx_all_ones_o,
  output wire [6:0]  f_bit_invert_o,
  output wire [69:0] fas_word_o,
  output wire [3:0]  e2_national_bit_o,
  output wire        e2_national_force_o,
  output wire [6:0]  frame_loss_o,
  output reg         master_status_o,
  output wire        irq_o
);

  reg  [6:0] tx_remote_alarm_ch_reg;
  reg  [6:0] tx_all_ones_ch_reg;
  reg  [6:0] frame_error_inject_ch_reg;
  reg  [6:0] inject_prev_reg;
  reg  [3:0] e2_national_bit_ch_reg;
  reg  [6:0] frame_loss_latched_ch_reg;
  reg  [6:0] all_ones_latched_ch_reg;
  reg        frame_loss_irq_enable_reg;
  reg        all_ones_irq_enable_reg;
  reg  [6:0] lof_prev_reg;
  reg  [6:0] ais_prev_reg;
  reg  [15:0] rdata_next;
  wire [6:0] lof_now;
  wire [6:0] inject_active;
  wire [6:0] inject_rise;
  wire       wr_alarm;
  wire       wr_inj;
  wire       wr_stat;
  wire       rd_stat;
  wire       change_req;
  wire       is_t3;

  assign wr_alarm = wr_i && (addr_i == `TFCS_ADDR_ALARM_CTRL);
  assign wr_inj   = wr_i && (addr_i == `TFCS_ADDR_ERRINJ_CTRL);
  assign wr_stat  = wr_i && (addr_i == `TFCS_ADDR_STATUS);
  assign rd_stat  = rd_i && (addr_i == `TFCS_ADDR_STATUS);
  assign is_t3    = (mode_i == `TFCS_MODE_T3);

  assign inject_rise = frame_error_inject_ch_reg & ~inject_prev_reg;

  genvar ch;
  generate
    for (ch = 0; ch < 7; ch = ch + 1)
    begin : g_ch
      tfcs_chan u_chan
      (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .mode_i          (mode_i),
        .align_strobe_i  (align_strobe_i[ch]),
        .align_bad_i     (align_bad_i[ch]),
        .fbit_strobe_i   (fbit_strobe_i[ch]),
        .fbit_err_i      (fbit_err_i[ch]),
        .mbit_strobe_i   (mbit_strobe_i[ch]),
        .mbit_err_i      (mbit_err_i[ch]),
        .t2_sync_i       (t2_sync_i[ch]),
        .inject_rise_i   (inject_rise[ch]),
        .frame_mark_i    (frame_mark_i[ch]),
        .frame_loss_o    (lof_now[ch]),
        .inject_active_o (inject_active[ch]),
        .fas_word_o      (fas_word_o[ch*10 +: 10])
      );
    end
  endgenerate

  // T3 sends X low for alarm; E3 and G.747 send RAI high for alarm
  assign overhead_alarm_bit_o = is_t3 ? ~tx_remote_alarm_ch_reg
                                      : tx_remote_alarm_ch_reg;
  assign tx_all_ones_o        = tx_all_ones_ch_reg;
  assign f_bit_invert_o       = is_t3 ? inject_active : 7'h00;
  assign e2_national_bit_o    = e2_national_bit_ch_reg;
  assign e2_national_force_o  = (mode_i == `TFCS_MODE_E3);
  assign frame_loss_o         = lof_now;

  assign change_req = |(((lof_now ^ lof_prev_reg) & {7{frame_loss_irq_enable_reg}}) |
                        ((all_ones_det_i ^ ais_prev_reg) & {7{all_ones_irq_enable_reg}}));

  assign irq_o = master_status_o & master_mask_i;

  always @*
  begin
    rdata_next = 16'h0000;
    case (addr_i)
      `TFCS_ADDR_ALARM_CTRL:
        rdata_next = {1'b0, tx_all_ones_ch_reg, 1'b0, tx_remote_alarm_ch_reg};
      `TFCS_ADDR_ERRINJ_CTRL:
        rdata_next = {4'h0, e2_national_bit_ch_reg, 1'b0, frame_error_inject_ch_reg};
      `TFCS_ADDR_STATUS:
        rdata_next = {all_ones_irq_enable_reg, all_ones_latched_ch_reg,
                      frame_loss_irq_enable_reg, frame_loss_latched_ch_reg};
      default:
        rdata_next = 16'h0000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_remote_alarm_ch_reg    <= `TFCS_CH_RESET;
      tx_all_ones_ch_reg        <= `TFCS_CH_RESET;
      frame_error_inject_ch_reg <= `TFCS_CH_RESET;
      inject_prev_reg           <= `TFCS_CH_RESET;
      e2_national_bit_ch_reg    <= `TFCS_NAT_RESET;
      frame_loss_latched_ch_reg <= `TFCS_CH_RESET;
      all_ones_latched_ch_reg   <= `TFCS_CH_RESET;
      frame_loss_irq_enable_reg <= `TFCS_IE_RESET;
      all_ones_irq_enable_reg   <= `TFCS_IE_RESET;
      lof_prev_reg              <= `TFCS_CH_RESET;
      ais_prev_reg              <= `TFCS_CH_RESET;
      master_status_o           <= 1'b0;
      rdata_o                   <= 16'h0000;
    end
    else
    begin
      inject_prev_reg <= frame_error_inject_ch_reg;
      lof_prev_reg    <= lof_now;
      ais_prev_reg    <= all_ones_det_i;
      if (wr_alarm)
      begin
        tx_remote_alarm_ch_reg <= wdata_i[`TFCS_RAI_LSB +: 7];
        tx_all_ones_ch_reg     <= wdata_i[`TFCS_AIS_CTRL_LSB +: 7];
      end
      if (wr_inj)
      begin
        frame_error_inject_ch_reg <= wdata_i[`TFCS_INJ_LSB +: 7];
        e2_national_bit_ch_reg    <= wdata_i[`TFCS_NAT_LSB +: 4];
      end
      if (wr_stat)
      begin
        frame_loss_irq_enable_reg <= wdata_i[`TFCS_IE_LOF_BIT];
        all_ones_irq_enable_reg   <= wdata_i[`TFCS_IE_AIS_BIT];
      end
      // Live condition wins over the read clear
      frame_loss_latched_ch_reg <= lof_now |
        (frame_loss_latched_ch_reg & {7{~rd_stat}});
      all_ones_latched_ch_reg   <= all_ones_det_i |
        (all_ones_latched_ch_reg & {7{~rd_stat}});
      master_status_o <= change_req | (master_status_o & ~rd_stat);
      rdata_o <= rd_i ? rdata_next : 16'h0000;
    end
  end

endmodule
`default_nettype wire

/* tfcs_ctrl_status_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module tfcs_sva
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [1:0]  mode_i,
  input wire logic        master_mask_i,
  input wire logic [6:0]  overhead_alarm_bit_o,
  input wire logic [6:0]  tx_all_ones_o,
  input wire logic [69:0] fas_word_o,
  input wire logic [3:0]  e2_national_bit_o,
  input wire logic        e2_national_force_o,
  input wire logic [6:0]  frame_loss_o,
  input wire logic        master_status_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_XBIT: assert property (wr_i && addr_i == 8'h30 && mode_i == 2'h0 ##1 mode_i == 2'h0
    |-> overhead_alarm_bit_o == ~$past(wdata_i[6:0])) else $error("x bit wrong");
  AST_RAI: assert property (wr_i && addr_i == 8'h30 && mode_i != 2'h0 ##1 mode_i != 2'h0
    |-> overhead_alarm_bit_o == $past(wdata_i[6:0])) else $error("rai bit wrong");
  AST_AISC: assert property (wr_i && addr_i == 8'h30 |=>
    tx_all_ones_o == $past(wdata_i[14:8])) else $error("all ones ctrl wrong");
  AST_NATF: assert property (mode_i != 2'h3 |->
    e2_national_force_o == (mode_i == 2'h1)) else $error("national force wrong");
  AST_NATB: assert property (wr_i && addr_i == 8'h32 |=>
    e2_national_bit_o == $past(wdata_i[11:8])) else $error("national bits wrong");
  AST_IRQ: assert property (irq_o == (master_status_o && master_mask_i))
    else $error("irq gating wrong");
  AST_FAS: assert property (mode_i == 2'h1 |->
    fas_word_o[9:0] inside {10'h3d0, 10'h02f}) else $error("fas word wrong");
  AST_LOFL: assert property (rd_i && addr_i == 8'h34 |=>
    (rdata_o[6:0] & $past(frame_loss_o, 2)) == $past(frame_loss_o, 2))
    else $error("frame loss latch lost");

  cover property (wr_i && addr_i == 8'h30);
  cover property ($rose(frame_loss_o[0]));
  cover property (irq_o);
endmodule

bind tfcs_ctrl_status tfcs_sva u_sva (.*);
`default_nettype wire

/* tfcs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic [7:0]      addr_i = 8'h00;
  logic [15:0]     wdata_i = 16'h0000;
  logic            wr_i = 1'b0;
  logic            rd_i = 1'b0;
  logic [1:0]      mode_i = 2'h0;
  logic [4:0][6:0] st = 35'h0;
  logic [6:0]      er = 7'h00;
  logic [6:0]      all_ones_det_i = 7'h00;
  logic            master_mask_i = 1'b0;
  logic [15:0]     rdata_o;
  logic [6:0]      overhead_alarm_bit_o, tx_all_ones_o, f_bit_invert_o, frame_loss_o;
  logic [69:0]     fas_word_o;
  logic [3:0]      e2_national_bit_o;
  logic            e2_national_force_o, master_status_o, irq_o;
  int              failures = 0, total_checks = 0, cyc = 0;
  logic [31:0]     r = 32'h7d2804a7;
  logic [15:0]     q;
  logic [15:0]     w;
  logic [6:0]      c;

  tfcs_ctrl_status u_dut (.*, .align_strobe_i(st[0]), .fbit_strobe_i(st[1]),
    .mbit_strobe_i(st[2]), .t2_sync_i(st[3]), .frame_mark_i(st[4]),
    .align_bad_i(er), .fbit_err_i(er), .mbit_err_i(er));

  always #10 clk_i = ~clk_i;

  task end_sim;
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  function [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function [6:0] xb(input logic [1:0] m, input logic [6:0] t);
    xb = m == 2'h0 ? ~t : t;
  endfunction

  function [15:0] val(input int k);
    val = k == 0 ? frame_loss_o : k == 1 ? f_bit_invert_o : fas_word_o[9:0];
  endfunction

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask

  // One strobe pulse: 0 align, 1 F bit, 2 M bit, 3 sync, 4 frame mark
  task ev(input int k, input logic [6:0] m, input logic [6:0] e);
    @(posedge clk_i);
    st[k] <= m;
    er <= e;
    @(posedge clk_i);
    st <= 35'h0;
  endtask

  task wt(input int k, input logic [15:0] e);
    #1;
    for (int n = 0; n < 8 && val(k) !== e; n++)
      @(posedge clk_i) #1;
    chk(val(k), e);
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      end_sim;
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(overhead_alarm_bit_o, 7'h7f);
    rd(8'h34);
    chk(q, 16'h0000);
    for (int i = 0; i < 12; i++)
    begin
      r = nx(r);
      // E3 has only four tributaries: upper control bits stay clear
      w = (i % 3 == 1) ? (r[15:0] & 16'h0f0f) : r[15:0];
      @(posedge clk_i);
      mode_i <= 2'(i % 3);
      wr(8'h30, w);
      wr(8'h32, r[31:16]);
      rd(8'h30);
      chk(q, w & 16'h7f7f);
      rd(8'h32);
      chk(q, r[31:16] & 16'h0f7f);
      chk(overhead_alarm_bit_o, xb(mode_i, w[6:0]));
      chk(tx_all_ones_o, w[14:8]);
      chk(e2_national_bit_o, r[27:24]);
      chk(e2_national_force_o, mode_i == 2'h1);
    end
    wr(8'h30, 16'hffff);
    wr(8'h36, 16'h0000);
    rd(8'h30);
    chk(q, 16'h7f7f);
    rd(8'h36);
    chk(q, 16'h0000);
    wr(8'h34, 16'hffff);
    rd(8'h34);
    chk(q, 16'h8080);
    wr(8'h30, 16'h0000);
    @(posedge clk_i);
    master_mask_i <= 1'b1;
    mode_i <= 2'h1;
    // Events only on the four tributaries that exist in E3
    c = 7'h01 << (r % 4);
    repeat (3) ev(0, c, c);
    repeat (2) @(posedge clk_i);
    #1 chk(frame_loss_o, 7'h00);
    ev(0, c, c);
    wt(0, c);
    @(posedge clk_i);
    #1 chk(irq_o, 1'b1);
    repeat (3) ev(0, c, 7'h00);
    wt(0, 16'h0000);
    @(posedge clk_i);
    rd(8'h34);
    chk(q, 16'h8080 | c);
    chk(master_status_o, 1'b0);
    rd(8'h34);
    chk(q, 16'h8080);
    @(posedge clk_i);
    master_mask_i <= 1'b0;
    all_ones_det_i <= c;
    repeat (3) @(posedge clk_i);
    #1 chk(master_status_o, 1'b1);
    chk(irq_o, 1'b0);
    rd(8'h34);
    chk(q, {c, 8'h00} | 16'h8080);
    @(posedge clk_i);
    all_ones_det_i <= 7'h00;
    repeat (3) @(posedge clk_i);
    rd(8'h34);
    chk(q, {c, 8'h00} | 16'h8080);
    rd(8'h34);
    chk(q, 16'h8080);
    wr(8'h34, 16'h0000);
    @(posedge clk_i);
    all_ones_det_i <= c;
    repeat (3) @(posedge clk_i);
    #1 chk(master_status_o, 1'b0);
    @(posedge clk_i);
    mode_i <= 2'h0;
    ev(1, c, c);
    ev(1, c, 7'h00);
    ev(1, c, c);
    wt(0, c);
    ev(3, c, 7'h00);
    wt(0, 16'h0000);
    repeat (2) ev(2, c, c);
    wt(0, c);
    // Live conditions survive the read clear
    rd(8'h34);
    chk(q, {1'b0, c, 1'b0, c});
    rd(8'h34);
    chk(q, {1'b0, c, 1'b0, c});
    ev(3, c, 7'h00);
    repeat (4) ev(4, 7'h7f, 7'h00);
    wr(8'h32, 16'h0000);
    wr(8'h32, 16'h0001);
    wt(1, 16'h0001);
    repeat (3) ev(4, 7'h01, 7'h00);
    #1 chk(f_bit_invert_o, 7'h01);
    ev(4, 7'h01, 7'h00);
    wt(1, 16'h0000);
    wr(8'h32, 16'h0001);
    repeat (3) @(posedge clk_i);
    #1 chk(f_bit_invert_o, 7'h00);
    for (int m = 1; m < 3; m++)
    begin
      @(posedge clk_i);
      mode_i <= 2'(m);
      wr(8'h32, 16'h0000);
      wr(8'h32, 16'h0001);
      wt(2, 16'h002f);
      repeat (4) ev(4, 7'h01, 7'h00);
      wt(2, m == 1 ? 16'h03d0 : 16'h01d0);
    end
    end_sim;
  end
endmodule
`default_nettype wire
